/* rtl/trng_core.sv */
// Purpose: Physical random word generator with health and malfunction tests
// Assumes: Raw entropy bits arrive synchronous to clk_sys_i with a valid strobe
// Notes:   Any failure is sticky until reset
// Behaviour
// - Random output is 16-bit words built from the physical entropy source.
// - Raw bit pairs are debiased: equal pairs dropped, unequal give one bit.
// - Total-failure and continuous online tests run while generating.
// - Severe entropy loss marks generator unusable; output is withheld.
// - Post-processing and control malfunction stops word production.
// - Delivered words must pass statistical test procedure A.
`timescale 1ns/100ps
module trng_core
	import trng_pkg::*;
#(
	parameter int PAIR_TMO = trng_pkg::PAIR_TMO_CYC
)
(
	// Clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	// Control
	input  wire logic                        enable_i,
	// Entropy source
	input  wire logic                        raw_bit_i,
	input  wire logic                        raw_valid_i,
	// Word output
	output logic [trng_pkg::WORD_W-1:0]      word_o,
	output logic                             word_valid_o,
	input  wire logic                        word_ready_i,
	// Status
	output logic                             running_o,
	output logic                             fail_o,
	output logic                             fail_entropy_o,
	output logic                             fail_logic_o
);
	import trng_pkg::*;

	function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
		inc = (v == {CNT_W{1'b1}}) ? v : v + 16'h0001;
	endfunction

	trng_state_t              state_reg, state_next;
	logic [WORD_W-1:0]        shift_reg, shift_next;
	logic [4:0]               nbits_reg, nbits_next;
	logic [WORD_W-1:0]        word_reg, word_next;
	logic                     wvalid_reg, wvalid_next;
	logic                     last_raw_reg, last_raw_next;
	logic [CNT_W-1:0]         rep_reg, rep_next;
	logic [CNT_W-1:0]         tmo_reg, tmo_next;
	logic [CNT_W-1:0]         win_reg, win_next;
	logic [CNT_W-1:0]         ones_reg, ones_next;
	logic                     fent_reg, fent_next;
	logic                     flog_reg, flog_next;
	logic                     vn_bit;
	logic                     vn_valid;
	logic                     pair_done;
	logic                     active;

	assign active = (state_reg == ST_RUN);

	vn_debias u_vn
	(
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.clear_i     (!active),
		.raw_bit_i   (raw_bit_i),
		.raw_valid_i (raw_valid_i),
		.vn_bit_o    (vn_bit),
		.vn_valid_o  (vn_valid),
		.pair_done_o (pair_done)
	);

	// ==========================================================
	// Health tests
	// ==========================================================
	always_comb
	begin
		last_raw_next = last_raw_reg;
		rep_next      = rep_reg;
		tmo_next      = tmo_reg;
		win_next      = win_reg;
		ones_next     = ones_reg;
		fent_next     = fent_reg;
		flog_next     = flog_reg;
		if (!active)
		begin
			rep_next  = '0;
			tmo_next  = '0;
			win_next  = '0;
			ones_next = '0;
		end
		else
		begin
			// Total failure: source stuck at one level
			if (raw_valid_i)
			begin
				last_raw_next = raw_bit_i;
				rep_next      = (raw_bit_i == last_raw_reg) ? inc(rep_reg) : 16'h0000;
			end
			if (rep_reg >= CNT_W'(REP_LIMIT))
				fent_next = 1'b1;
			// Total failure: no pairs produced at all
			tmo_next = pair_done ? 16'h0000 : inc(tmo_reg);
			if (tmo_reg >= CNT_W'(PAIR_TMO))
				fent_next = 1'b1;
			// Online monobit test over debiased bits
			if (vn_valid)
			begin
				if (win_reg == CNT_W'(WIN_LEN - 1))
				begin
					win_next  = '0;
					ones_next = '0;
					if ((ones_reg + 16'(vn_bit)) < CNT_W'(ONES_MIN) ||
						(ones_reg + 16'(vn_bit)) > CNT_W'(ONES_MAX))
						fent_next = 1'b1;
				end
				else
				begin
					win_next  = win_reg + 16'h0001;
					ones_next = ones_reg + 16'(vn_bit);
				end
			end
			// Malfunction: counter or state out of range
			if (nbits_reg > 5'(WORD_W))
				flog_next = 1'b1;
		end
		if (state_reg != ST_IDLE && state_reg != ST_RUN && state_reg != ST_FAIL)
			flog_next = 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			last_raw_reg <= 1'b0;
			rep_reg      <= '0;
			tmo_reg      <= '0;
			win_reg      <= '0;
			ones_reg     <= '0;
			fent_reg     <= 1'b0;
			flog_reg     <= 1'b0;
		end
		else
		begin
			last_raw_reg <= last_raw_next;
			rep_reg      <= rep_next;
			tmo_reg      <= tmo_next;
			win_reg      <= win_next;
			ones_reg     <= ones_next;
			fent_reg     <= fent_next;
			flog_reg     <= flog_next;
		end
	end

	// ==========================================================
	// Control and word assembly
	// ==========================================================
	always_comb
	begin
		state_next  = state_reg;
		shift_next  = shift_reg;
		nbits_next  = nbits_reg;
		word_next   = word_reg;
		wvalid_next = wvalid_reg;
		case (state_reg)
			ST_IDLE:
			begin
				nbits_next = '0;
				if (enable_i)
					state_next = ST_RUN;
			end
			ST_RUN:
			begin
				if (wvalid_reg && word_ready_i)
					wvalid_next = 1'b0;
				if (vn_valid && nbits_reg < 5'(WORD_W))
				begin
					shift_next = {shift_reg[WORD_W-2:0], vn_bit};
					nbits_next = nbits_reg + 5'd1;
				end
				if (nbits_reg == 5'(WORD_W) && !wvalid_next)
				begin
					word_next   = shift_reg;
					wvalid_next = 1'b1;
					nbits_next  = '0;
				end
				if (!enable_i)
				begin
					state_next  = ST_IDLE;
					wvalid_next = 1'b0;
				end
			end
			ST_FAIL:
			begin
				wvalid_next = 1'b0;
			end
			default:
			begin
				state_next  = ST_FAIL;
				wvalid_next = 1'b0;
			end
		endcase
		if (fent_reg || flog_reg)
		begin
			state_next  = ST_FAIL;
			wvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_reg  <= ST_IDLE;
			shift_reg  <= '0;
			nbits_reg  <= '0;
			word_reg   <= '0;
			wvalid_reg <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			shift_reg  <= shift_next;
			nbits_reg  <= nbits_next;
			word_reg   <= word_next;
			wvalid_reg <= wvalid_next;
		end
	end

	// Valid is gated by the flags too, so a failure hides a word at once
	assign word_o         = word_reg;
	assign word_valid_o   = wvalid_reg && !fent_reg && !flog_reg;
	assign running_o      = active;
	assign fail_o         = fent_reg || flog_reg;
	assign fail_entropy_o = fent_reg;
	assign fail_logic_o   = flog_reg;
endmodule // trng_core

/* rtl/trng_pkg.sv */
// Purpose: Shared constants for the physical random word generator
// Assumes: One system clock at 40 MHz
// Notes:   Test windows and limits are plain defaults
package trng_pkg;
	localparam int WORD_W         = 16;
	localparam int REP_LIMIT      = 32;
	localparam int PAIR_TMO_NS    = 102400;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int PAIR_TMO_CYC   = PAIR_TMO_NS / CLK_PERIOD_NS;
	localparam int WIN_LEN        = 1024;
	localparam int ONES_MIN       = 384;
	localparam int ONES_MAX       = 640;
	localparam int CNT_W          = 16;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FAIL} trng_state_t;
endpackage

/* rtl/vn_debias.sv */
// Purpose: Pair-wise debiasing of raw entropy bits
// Assumes: raw_valid_i pulses one cycle per raw bit
// Notes:   Output bit is the first bit of an unequal pair
`timescale 1ns/100ps
module vn_debias
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	// Raw side
	input  wire logic clear_i,
	input  wire logic raw_bit_i,
	input  wire logic raw_valid_i,
	// Debiased side
	output logic      vn_bit_o,
	output logic      vn_valid_o,
	output logic      pair_done_o
);
	logic have_first_reg;
	logic have_first_next;
	logic first_reg;
	logic first_next;
	logic bit_reg;
	logic bit_next;
	logic valid_reg;
	logic valid_next;
	logic done_reg;
	logic done_next;

	always_comb
	begin
		have_first_next = have_first_reg;
		first_next      = first_reg;
		bit_next        = bit_reg;
		valid_next      = 1'b0;
		done_next       = 1'b0;
		if (clear_i)
		begin
			have_first_next = 1'b0;
		end
		else if (raw_valid_i)
		begin
			if (!have_first_reg)
			begin
				have_first_next = 1'b1;
				first_next      = raw_bit_i;
			end
			else
			begin
				have_first_next = 1'b0;
				done_next       = 1'b1;
				if (first_reg != raw_bit_i)
				begin
					bit_next   = first_reg;
					valid_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			have_first_reg <= 1'b0;
			first_reg      <= 1'b0;
			bit_reg        <= 1'b0;
			valid_reg      <= 1'b0;
			done_reg       <= 1'b0;
		end
		else
		begin
			have_first_reg <= have_first_next;
			first_reg      <= first_next;
			bit_reg        <= bit_next;
			valid_reg      <= valid_next;
			done_reg       <= done_next;
		end
	end

	assign vn_bit_o    = bit_reg;
	assign vn_valid_o  = valid_reg;
	assign pair_done_o = done_reg;
endmodule // vn_debias

/* testbench/trng_core_monitor.sv */
// Purpose: Port checker for trng_core
// Assumes: One clock, sync active-low reset
// Notes:   Bound after the module
`timescale 1ns/100ps
module trng_core_monitor
	import trng_pkg::*;
(
	// Watched ports
	input wire logic						clk_sys_i,
	input wire logic						rst_n_i,
	input wire logic						enable_i,
	input wire logic						word_ready_i,
	input wire logic [trng_pkg::WORD_W-1:0]	word_o,
	input wire logic						word_valid_o,
	input wire logic						running_o,
	input wire logic						fail_o,
	input wire logic						fail_entropy_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ====
	// Word offered, not taken
	sequence offer_s;
		word_valid_o && !word_ready_i && enable_i;
	endsequence
	reset_quiet_a: assert property ($rose(rst_n_i) |-> !word_valid_o && !running_o && !fail_o)
		else $error("outputs set after reset");
	idle_no_word_a: assert property (!running_o |-> !word_valid_o)
		else $error("word while idle");
	fail_no_word_a: assert property (fail_o |-> !word_valid_o)
		else $error("word after failure");
	fail_sticky_a: assert property (fail_o |=> fail_o)
		else $error("failure cleared");
	fail_merge_a: assert property (fail_entropy_o |-> fail_o ##1 !running_o)
		else $error("entropy failure not merged");
	word_hold_a: assert property (offer_s |=> fail_o || word_valid_o && $stable(word_o))
		else $error("word dropped before taken");
	run_stop_a: assert property (!enable_i |=> !running_o)
		else $error("run not left");
endmodule // trng_core_monitor

bind trng_core trng_core_monitor u_trng_core_monitor (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .word_ready_i(word_ready_i),
	.word_o(word_o), .word_valid_o(word_valid_o), .running_o(running_o), .fail_o(fail_o),
	.fail_entropy_o(fail_entropy_o));

/* testbench/word_consumer.sv */
// Purpose: Consumer taking offered words
// Assumes: Bench asks for stalls
// Notes:   Ready moves after the edge
`timescale 1ns/100ps
module word_consumer
(
	// Handshake
	input wire logic	clk_sys_i,
	input wire logic	stall_i,
	input wire logic	word_valid_i,
	output logic		word_ready_o = 1'b0
);
	always @(posedge clk_sys_i)
		word_ready_o <= #1 word_valid_i && !stall_i;
endmodule // word_consumer

/* testbench/tb_trng_core.sv */
// Purpose: Self-checking bench for trng_core
// Assumes: Pair timeout shortened to 64 cycles
// Notes:   Raw bits sent as unequal pairs
`timescale 1ns/100ps
module tb_trng_core;
	import trng_pkg::*;
	localparam int TMO = 64;
	logic				clk = 1'b0;
	logic				rst_n = 1'b0;
	logic				en = 1'b0;
	logic				rb = 1'b0;
	logic				rv = 1'b0;
	logic				stall = 1'b0;
	logic				rdy, vld, run, fl, fle, fll;
	logic [WORD_W-1:0]	word;
	logic [WORD_W-1:0]	got_q[$];
	int					num_errors = 0;
	int					num_checks = 0;
	always #12.5 clk = ~clk;
	// ====
	// Design and consumer
	trng_core #(.PAIR_TMO(TMO)) u_trng_core (.clk_sys_i(clk), .rst_n_i(rst_n), .enable_i(en),
		.raw_bit_i(rb), .raw_valid_i(rv), .word_o(word), .word_valid_o(vld), .word_ready_i(rdy),
		.running_o(run), .fail_o(fl), .fail_entropy_o(fle), .fail_logic_o(fll));
	word_consumer u_word_consumer (.clk_sys_i(clk), .stall_i(stall), .word_valid_i(vld),
		.word_ready_o(rdy));
	always @(posedge clk)
		if (vld === 1'b1 && rdy === 1'b1)
			got_q.push_back(word);
	// ====
	// Tasks
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(logic [WORD_W-1:0] got, logic [WORD_W-1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic drive(logic e, logic v, logic b);
		tick(1);
		en = e;
		rv = v;
		rb = b;
	endtask
	task automatic send(logic [WORD_W-1:0] w);
		// Enable one cycle ahead: bits before run entry are not taken
		drive(1'b1, 1'b0, 1'b0);
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			drive(1'b1, 1'b1, w[i]);
			drive(1'b1, 1'b1, !w[i]);
			// Equal pair or strobe gap
			drive(1'b1, i[0], 1'b0);
			drive(1'b1, i[0], 1'b0);
		end
	endtask
	task automatic take(logic [WORD_W-1:0] exp);
		for (int n = 0; n < 99 && got_q.size() == 0; n++)
			@(posedge clk);
		#1;
		chk(got_q.size() ? got_q.pop_front() : 16'hXXXX, exp);
	endtask
	task automatic do_reset();
		drive(1'b0, 1'b0, 1'b0);
		rst_n = 1'b0;
		tick(10);
		rst_n = 1'b1;
	endtask
	task automatic t_words();
		send(16'hA5C3);
		drive(1'b1, 1'b0, 1'b0);
		take(16'hA5C3);
		stall = 1'b1;
		send(16'h3C5A);
		send(16'h0F81);
		drive(1'b1, 1'b0, 1'b0);
		tick(20);
		stall = 1'b0;
		take(16'h3C5A);
		take(16'h0F81);
		chk(16'(fll), 16'h0000);
	endtask
	task automatic t_drop();
		for (int i = 0; i < 10; i++)
			drive(1'b1, 1'b1, i[0]);
		drive(1'b0, 1'b0, 1'b0);
		tick(2);
		chk(16'(run), 16'h0000);
		send(16'h1234);
		drive(1'b1, 1'b0, 1'b0);
		take(16'h1234);
		// Pending word withdrawn on disable
		stall = 1'b1;
		send(16'h5A5A);
		drive(1'b1, 1'b0, 1'b0);
		tick(3);
		chk(16'(vld), 16'h0001);
		drive(1'b0, 1'b0, 1'b0);
		tick(1);
		chk(16'(vld), 16'h0000);
		stall = 1'b0;
		tick(4);
		chk(16'(got_q.size()), 16'h0000);
	endtask
	task automatic t_stuck();
		repeat (REP_LIMIT + 8) drive(1'b1, 1'b1, 1'b1);
		drive(1'b1, 1'b0, 1'b0);
		tick(3);
		chk(16'({fl, fle, run, vld}), 16'h000C);
		do_reset();
		chk(16'({fl, fle, run, vld}), 16'h0000);
	endtask
	task automatic t_tmo();
		drive(1'b1, 1'b0, 1'b0);
		tick(TMO + 10);
		chk(16'({fl, fle, fll}), 16'h0006);
		do_reset();
	endtask
	task automatic t_mono();
		drive(1'b1, 1'b0, 1'b0);
		repeat (WIN_LEN)
		begin
			drive(1'b1, 1'b1, 1'b1);
			drive(1'b1, 1'b1, 1'b0);
		end
		drive(1'b1, 1'b0, 1'b0);
		tick(3);
		chk(16'({fl, fle, fll, run}), 16'h000C);
		chk(16'(got_q.size()), 16'(WIN_LEN / WORD_W - 1));
		take(16'hFFFF);
	endtask
	task automatic test_done();
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ====
	// Run
	initial
	begin
		#(CLK_PERIOD_NS * 6000);
		num_errors++;
		test_done();
	end
	initial
	begin
		do_reset();
		t_words();
		t_drop();
		t_stuck();
		t_tmo();
		t_mono();
		test_done();
	end
endmodule // tb_trng_core
